// [timer2_pkg.sv]
// Package with the register map, field positions and timing constants of the timer
package timer2_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_MODE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CONTROL_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h08;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h0C;
  localparam logic [7:0] OFS_RELOAD_LOW = 8'h10;
  localparam logic [7:0] OFS_RELOAD_HIGH = 8'h14;

  // ==========================================================================
  // Field positions in timer_mode_control
  localparam int MC_OVF_SW_CLEAR = 5;
  localparam int MC_EXT_SW_CLEAR = 4;
  localparam int MC_PRESCALE_HI = 3;
  localparam int MC_PRESCALE_LO = 2;
  localparam int MC_CLKOUT_ENABLE = 1;
  localparam int MC_DOWN_COUNT_ENABLE = 0;

  // Field positions in timer_control_status
  localparam int CS_OVERFLOW_FLAG = 7;
  localparam int CS_EXTERNAL_FLAG = 6;
  localparam int CS_SERIAL_SEL_HI = 5;
  localparam int CS_SERIAL_SEL_LO = 4;
  localparam int CS_EXTERNAL_ENABLE = 3;
  localparam int CS_RUN_CONTROL = 2;
  localparam int CS_COUNTER_SELECT = 1;
  localparam int CS_CAPTURE_RELOAD_SELECT = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_CONTROL_STATUS = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_RELOAD = 16'h0000;

  // ==========================================================================
  // Timing: one machine cycle is three oscillator periods
  localparam int CLK_PERIOD_NS = 10;
  localparam int MACHINE_CYCLE_NS = 30;
  localparam logic [1:0] MACHINE_CYCLE_CLKS = 2'(MACHINE_CYCLE_NS / CLK_PERIOD_NS);
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;

endpackage

// [timer2_core.sv]
// Sixteen-bit timer with capture, auto-reload, up/down, clock-out and baud ticks
// ============================================================================
// Contract
// - Count is two cascaded bytes, low byte carries into the high byte.
// - Overflow flag sticky when its software-clear bit is 1, else cleared on vectoring.
// - External flag sticky when its software-clear bit is 1, else cleared on vectoring.
// - Timer input is oscillator divided by three times prescaler plus one.
// - Nonzero serial select makes baud mode; capture/reload select then ignored.
// - Baud mode never sets the overflow flag.
// - Select zero: capture/reload and output enable pick reload, clock-out, capture, stopped.
// - Counter select picks prescaled clock or count pin falling edges.
// - Count advances only while run control is set.
// - Capture mode trigger falling edge copies count to reload pair, sets external flag.
// - Capture mode overflow sets the overflow flag, which can interrupt.
// - Auto-reload up overflow at FFFFH sets flag and loads the reload value.
// - Auto-reload up with external enable: trigger fall reloads and sets external flag.
// - One interrupt request while overflow or allowed external flag is set.
// - Reset clears down-count enable, so auto-reload counts up.
// - Up/down: trigger high counts up, low counts down to reload then loads FFFFH.
// - Up/down: external flag toggles on each wrap and never interrupts.
// - Clock-out: overflow reloads and toggles a half-rate stage onto the count pin.
// - Clock-out overflows set no interrupt request.
// - Trigger pin ignored without external enable (code still takes up/down direction from its level); never reloads or captures in baud mode.
// - Baud generation and clock-out can run together from the same overflows.
// - Baud mode high-byte rollover reloads both bytes from the reload pair.
// - Baud timer advances every one to four machine cycles per prescaler.
//
// Our own choices: the placing of the registers and the APB register port.
module timer2_core (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [timer2_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [timer2_pkg::DATA_W-1:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [timer2_pkg::DATA_W-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic IRQ_ACK_I,
  input wire logic EXT_TRIGGER_PIN_I,
  input wire logic COUNT_CLOCK_PIN_I,
  output logic COUNT_CLOCK_PIN_O,
  output logic COUNT_CLOCK_PIN_OE_O,
  output logic IRQ_O,
  output logic BAUD_TICK_O,
  output logic [1:0] SERIAL_PORT_SELECT_O
);
  import timer2_pkg::*;

  // Falling edge between two successive machine-cycle samples
  function automatic logic fell(input logic prev, input logic now);
    fell = prev & ~now;
  endfunction

  // Address match for one register offset
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ==========================================================================
  // State
  logic [7:0] mode_q;
  logic [7:0] ctrl_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] reload_q;
  logic [15:0] reload_d;
  logic ovf_flag_q;
  logic ovf_flag_d;
  logic ext_flag_q;
  logic ext_flag_d;
  logic [1:0] mc_cnt_q;
  logic [1:0] pre_cnt_q;
  logic trig_s1_q;
  logic trig_s2_q;
  logic trig_smp_q;
  logic cpin_s1_q;
  logic cpin_s2_q;
  logic cpin_smp_q;
  logic toggle_q;
  logic pready_q;
  logic pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic irq_q;
  logic baud_tick_q;
  logic oe_q;

  // ==========================================================================
  // Field decode
  wire ovf_sw_clear = mode_q[MC_OVF_SW_CLEAR];
  wire ext_sw_clear = mode_q[MC_EXT_SW_CLEAR];
  wire [1:0] prescale_sel = mode_q[MC_PRESCALE_HI:MC_PRESCALE_LO];
  wire clkout_enable = mode_q[MC_CLKOUT_ENABLE];
  wire down_count_enable = mode_q[MC_DOWN_COUNT_ENABLE];
  wire [1:0] serial_port_select = ctrl_q[CS_SERIAL_SEL_HI:CS_SERIAL_SEL_LO];
  wire external_enable = ctrl_q[CS_EXTERNAL_ENABLE];
  wire run_control = ctrl_q[CS_RUN_CONTROL];
  wire counter_select = ctrl_q[CS_COUNTER_SELECT];
  wire capture_reload_select = ctrl_q[CS_CAPTURE_RELOAD_SELECT];

  // Mode selection; baud mode overrides the capture/reload select
  wire baud_mode = |serial_port_select;
  wire capture_mode = ~baud_mode & capture_reload_select & ~clkout_enable;
  wire stopped_mode = ~baud_mode & capture_reload_select & clkout_enable;
  wire clkout_only = ~baud_mode & ~capture_reload_select & clkout_enable;
  wire reload_mode = ~baud_mode & ~capture_reload_select & ~clkout_enable;
  // Clock-out may run beside baud generation; needs the internal clock input
  wire clkout_active = clkout_enable & ~counter_select & (baud_mode | ~capture_reload_select);
  wire updown_mode = reload_mode & down_count_enable;

  // ==========================================================================
  // Machine-cycle enable and prescaler
  wire mc_tick = (mc_cnt_q == 2'(MACHINE_CYCLE_CLKS - 2'h1));
  wire pre_tick = mc_tick & (pre_cnt_q == prescale_sel);

  // Edge detection on synchronised, machine-cycle sampled pins
  wire trig_fall = mc_tick & fell(trig_smp_q, trig_s2_q);
  wire cpin_fall = mc_tick & fell(cpin_smp_q, cpin_s2_q) & ~oe_q;
  wire count_up = ~updown_mode | trig_s2_q;

  // Count step from the selected input
  wire step = run_control & ~stopped_mode & (counter_select ? cpin_fall : pre_tick);
  wire at_top = (count_q == COUNT_TOP);
  wire overflow = step & count_up & at_top;
  wire underflow = step & ~count_up & (count_q == reload_q);
  wire wrap = overflow | underflow;
  // Low byte carries into the high byte
  wire [7:0] low_inc = count_q[7:0] + 8'h01;
  wire low_carry = (count_q[7:0] == 8'hFF);
  wire [7:0] high_inc = low_carry ? (count_q[15:8] + 8'h01) : count_q[15:8];
  wire [15:0] count_dec = count_q - 16'h0001;

  // Trigger-pin events; capture and reload never in baud mode or up/down mode
  wire trig_event = trig_fall & external_enable;
  wire trig_capture = trig_event & capture_mode;
  wire trig_reload = trig_event & reload_mode & ~down_count_enable;

  // ==========================================================================
  // APB decode; one wait state, writes take effect at the completing edge
  wire apb_access = PSEL_I & PENABLE_I;
  wire apb_done = apb_access & pready_q;
  wire apb_wr = apb_done & PWRITE_I & PSTRB_I[0];
  wire sel_mode = hit(PADDR_I, OFS_MODE_CONTROL);
  wire sel_ctrl = hit(PADDR_I, OFS_CONTROL_STATUS);
  wire sel_cl = hit(PADDR_I, OFS_COUNT_LOW);
  wire sel_ch = hit(PADDR_I, OFS_COUNT_HIGH);
  wire sel_rl = hit(PADDR_I, OFS_RELOAD_LOW);
  wire sel_rh = hit(PADDR_I, OFS_RELOAD_HIGH);
  wire sel_any = sel_mode | sel_ctrl | sel_cl | sel_ch | sel_rl | sel_rh;
  wire [7:0] wbyte = PWDATA_I[7:0];
  wire [7:0] ctrl_view = {ovf_flag_q, ext_flag_q, ctrl_q[5:0]};
  wire [7:0] rd_byte = sel_mode ? {2'h0, mode_q[5:0]} :
                       sel_ctrl ? ctrl_view :
                       sel_cl ? count_q[7:0] :
                       sel_ch ? count_q[15:8] :
                       sel_rl ? reload_q[7:0] :
                       sel_rh ? reload_q[15:8] : 8'h00;

  // ==========================================================================
  // Next count: software write, then trigger reload, then count step
  always_comb begin
    count_d = count_q;
    if (trig_reload) begin
      count_d = reload_q;
    end else if (overflow) begin
      if (capture_mode) begin
        count_d = 16'h0000;
      end else begin
        count_d = reload_q;
      end
    end else if (underflow) begin
      count_d = COUNT_TOP;
    end else if (step) begin
      count_d = count_up ? {high_inc, low_inc} : count_dec;
    end
    if (apb_wr && sel_cl) begin
      count_d[7:0] = wbyte;
    end
    if (apb_wr && sel_ch) begin
      count_d[15:8] = wbyte;
    end
  end

  // Next reload pair: capture takes the running count
  always_comb begin
    reload_d = reload_q;
    if (trig_capture) begin
      reload_d = count_q;
    end
    if (apb_wr && sel_rl) begin
      reload_d[7:0] = wbyte;
    end
    if (apb_wr && sel_rh) begin
      reload_d[15:8] = wbyte;
    end
  end

  // Overflow flag: hardware set wins over any clear
  always_comb begin
    ovf_flag_d = ovf_flag_q;
    if (IRQ_ACK_I && !ovf_sw_clear) begin
      ovf_flag_d = 1'b0;
    end
    if (apb_wr && sel_ctrl) begin
      ovf_flag_d = wbyte[CS_OVERFLOW_FLAG];
    end
    if (wrap && !baud_mode && !clkout_only) begin
      ovf_flag_d = 1'b1;
    end
  end

  // External flag: set by trigger edges, toggled as a seventeenth bit in up/down
  always_comb begin
    ext_flag_d = ext_flag_q;
    if (IRQ_ACK_I && !ext_sw_clear) begin
      ext_flag_d = 1'b0;
    end
    if (apb_wr && sel_ctrl) begin
      ext_flag_d = wbyte[CS_EXTERNAL_FLAG];
    end
    if (updown_mode && wrap) begin
      ext_flag_d = ~ext_flag_q;
    end else if (trig_event && !updown_mode) begin
      ext_flag_d = 1'b1;
    end
  end

  // External flag does not interrupt in up/down mode
  wire irq_d = ovf_flag_d | (ext_flag_d & ~updown_mode);

  // ==========================================================================
  // Machine-cycle divider and prescaler counter
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mc_cnt_q <= 2'h0;
      pre_cnt_q <= 2'h0;
    end else begin
      mc_cnt_q <= mc_tick ? 2'h0 : mc_cnt_q + 2'h1;
      if (pre_tick) begin
        pre_cnt_q <= 2'h0;
      end else if (mc_tick) begin
        pre_cnt_q <= pre_cnt_q + 2'h1;
      end
    end
  end

  // Pin synchronisers and per-machine-cycle samples
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      trig_s1_q <= 1'b1;
      trig_s2_q <= 1'b1;
      trig_smp_q <= 1'b1;
      cpin_s1_q <= 1'b1;
      cpin_s2_q <= 1'b1;
      cpin_smp_q <= 1'b1;
    end else begin
      trig_s1_q <= EXT_TRIGGER_PIN_I;
      trig_s2_q <= trig_s1_q;
      cpin_s1_q <= COUNT_CLOCK_PIN_I;
      cpin_s2_q <= cpin_s1_q;
      if (mc_tick) begin
        trig_smp_q <= trig_s2_q;
        cpin_smp_q <= cpin_s2_q;
      end
    end
  end

  // Control registers; reset clears down-count enable
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mode_q <= RST_MODE_CONTROL;
      ctrl_q <= RST_CONTROL_STATUS;
    end else begin
      if (apb_wr && sel_mode) begin
        mode_q <= {2'h0, wbyte[5:0]};
      end
      if (apb_wr && sel_ctrl) begin
        ctrl_q <= {2'h0, wbyte[5:0]};
      end
    end
  end

  // Count, reload pair and flags
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      count_q <= RST_COUNT;
      reload_q <= RST_RELOAD;
      ovf_flag_q <= 1'b0;
      ext_flag_q <= 1'b0;
    end else begin
      count_q <= count_d;
      reload_q <= reload_d;
      ovf_flag_q <= ovf_flag_d;
      ext_flag_q <= ext_flag_d;
    end
  end

  // Half-rate clock-out stage and pin drive
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      toggle_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= clkout_active;
      if (clkout_active && overflow) begin
        toggle_q <= ~toggle_q;
      end
    end
  end

  // Interrupt request and baud overflow tick
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      irq_q <= 1'b0;
      baud_tick_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      baud_tick_q <= baud_mode & overflow;
    end
  end

  // APB answer: ready in the second access cycle, error on unmapped address
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= apb_access & ~pready_q;
      if (apb_access && !pready_q) begin
        pslverr_q <= ~sel_any;
        prdata_q <= {24'h000000, rd_byte};
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Outputs, each straight from a flip-flop
  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign IRQ_O = irq_q;
  assign BAUD_TICK_O = baud_tick_q;
  assign SERIAL_PORT_SELECT_O = ctrl_q[CS_SERIAL_SEL_HI:CS_SERIAL_SEL_LO];
  assign COUNT_CLOCK_PIN_O = toggle_q;
  assign COUNT_CLOCK_PIN_OE_O = oe_q;

endmodule

// [timer2_core_chk.sv]
// Concurrent checks on the timer ports, attached to the design by bind
module timer2_core_chk (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [timer2_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [timer2_pkg::DATA_W-1:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic [timer2_pkg::DATA_W-1:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic COUNT_CLOCK_PIN_O,
  input wire logic BAUD_TICK_O,
  input wire logic [1:0] SERIAL_PORT_SELECT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  import timer2_pkg::*;
  logic [1:0] sel_w_q;
  wire cs_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PSTRB_I[0] && PADDR_I == OFS_CONTROL_STATUS;
  // Remember the serial select written by the last control write
  always_ff @(posedge CLK_I) begin
    if (cs_wr) sel_w_q <= PWDATA_I[5:4];
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ==========================================================================
  // Bus answer timing
  chk_ready_wait: assert property (PSEL_I && PENABLE_I && !$past(PENABLE_I) |-> !PREADY_O ##1 PREADY_O)
    else $error("ready not in second access cycle");
  chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O) else $error("ready held too long");
  chk_ready_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I) else $error("ready outside access");
  chk_rdata_upper: assert property (PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_refuse_zero: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
    else $error("refused access not clean");
  // ==========================================================================
  // Timer outputs
  chk_select_copy: assert property (cs_wr |-> ##2 SERIAL_PORT_SELECT_O == sel_w_q)
    else $error("port select not copied");
  chk_baud_tick: assert property (BAUD_TICK_O |-> SERIAL_PORT_SELECT_O != 2'b00 ##1 !BAUD_TICK_O)
    else $error("tick without port select");
  chk_clkout_half: assert property ($changed(COUNT_CLOCK_PIN_O) |=> $stable(COUNT_CLOCK_PIN_O) [*2])
    else $error("clock-out half period too short");
endmodule

bind timer2_core timer2_core_chk chk_i (.CLK_I, .RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
  .PSTRB_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .COUNT_CLOCK_PIN_O, .BAUD_TICK_O, .SERIAL_PORT_SELECT_O);

// [timer2_pins.sv]
// Far-side model of the trigger pin and the shared count clock pin
module timer2_pins (
  input wire logic clk_i,
  input wire logic drive_i,
  input wire logic drive_en_i,
  output logic trigger_o,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic level_q = 1'b1;
  // Design drives the pin while enabled, else this model, idling high on the pull-up
  assign pin_o = drive_en_i ? drive_i : level_q;
  initial trigger_o = 1'b1;
  // Each level stays two machine cycles so one sample a machine cycle sees it
  task automatic fall();
    level_q <= 1'b0;
    repeat (6) @(posedge clk_i);
    level_q <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic set_trig(input logic v);
    trigger_o <= v;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic trig_fall();
    set_trig(1'b0);
    set_trig(1'b1);
  endtask
endmodule

// [test_timer2_capture_reload_clockout.sv]
// Self-checking bench for the timer over APB with its pin partner
module test_timer2_capture_reload_clockout;
  timeunit 1ns;
  timeprecision 1ps;
  import timer2_pkg::*;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ack = 0, pin_q = 0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, pin_o, pin_oe, irq, tick, trig, pin_i;
  logic [1:0] ssel;
  logic [32:0] exp_q[$];
  int failures = 0, samples_checked = 0, cyc = 0, ticks = 0, togs = 0;
  always #5 clk = ~clk;
  timer2_core dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .IRQ_ACK_I(ack), .EXT_TRIGGER_PIN_I(trig), .COUNT_CLOCK_PIN_I(pin_i),
    .COUNT_CLOCK_PIN_O(pin_o), .COUNT_CLOCK_PIN_OE_O(pin_oe), .IRQ_O(irq), .BAUD_TICK_O(tick),
    .SERIAL_PORT_SELECT_O(ssel));
  timer2_pins pins (.clk_i(clk), .drive_i(pin_o), .drive_en_i(pin_oe), .trigger_o(trig), .pin_o(pin_i));
  // ==========================================================================
  // Comparison, bus cycles and closing report
  task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [32:0] e);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    if (!w) exp_q.push_back(e);
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    apb(0, a, 8'h00, {25'h0, v});
  endtask
  task automatic wr2(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h04, v[15:8]);
  endtask
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Read answers against the oldest note, event counters and the hang limit
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1 && !pwr) chk("read data", exp_q.pop_front(), {pslverr, prdata});
    ticks <= ticks + int'(tick);
    togs <= togs + int'(pin_o !== pin_q);
    pin_q <= pin_o;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      conclude();
    end
  end
  // ==========================================================================
  // Scenarios
  initial begin
    logic [15:0] r;
    logic [15:0] v;
    int t0;
    int t1;
    void'($urandom(32'h120D157B));
    r = 16'($urandom);
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int a = 0; a < 24; a += 4) rd(8'(a), 8'h00);
    apb(0, 8'h18, 8'h00, {1'b1, 32'h0});
    v = 16'($urandom);
    wr(OFS_MODE_CONTROL, v[7:0]);
    rd(OFS_MODE_CONTROL, v[7:0] & 8'h3F);
    // Pin edges: carry, overflow reload, run control
    wr(OFS_MODE_CONTROL, 8'h00);
    wr2(OFS_RELOAD_LOW, r);
    wr2(OFS_COUNT_LOW, 16'h00FE);
    wr(OFS_CONTROL_STATUS, 8'h06);
    repeat (2) pins.fall();
    rd(OFS_COUNT_LOW, 8'h00);
    rd(OFS_COUNT_HIGH, 8'h01);
    wr2(OFS_COUNT_LOW, 16'hFFFF);
    pins.fall();
    rd(OFS_COUNT_LOW, r[7:0]);
    rd(OFS_COUNT_HIGH, r[15:8]);
    rd(OFS_CONTROL_STATUS, 8'h86);
    chk("irq", 33'h1, 33'(irq));
    wr(OFS_CONTROL_STATUS, 8'h02);
    pins.fall();
    rd(OFS_COUNT_LOW, r[7:0]);
    // Trigger reloads only with the external enable set
    for (int x = 0; x < 2; x++) begin
      wr(OFS_COUNT_LOW, 8'h55);
      wr(OFS_CONTROL_STATUS, {4'h0, x[0], 3'b110});
      pins.trig_fall();
      rd(OFS_COUNT_LOW, x ? r[7:0] : 8'h55);
      rd(OFS_CONTROL_STATUS, {1'b0, x[0], 2'b00, x[0], 3'b110});
      chk("irq", 33'(x), 33'(irq));
    end
    // Capture, capture overflow, acknowledge under each clear choice
    for (int s = 0; s < 2; s++) begin
      v = 16'($urandom);
      wr(OFS_MODE_CONTROL, {2'b00, s[0], s[0], 4'h0});
      wr2(OFS_COUNT_LOW, v);
      wr(OFS_CONTROL_STATUS, 8'h0F);
      pins.trig_fall();
      rd(OFS_RELOAD_LOW, v[7:0]);
      rd(OFS_RELOAD_HIGH, v[15:8]);
      wr2(OFS_COUNT_LOW, 16'hFFFF);
      pins.fall();
      rd(OFS_CONTROL_STATUS, 8'hCF);
      ack <= 1;
      @(posedge clk);
      ack <= 0;
      rd(OFS_CONTROL_STATUS, {s[0], s[0], 6'h0F});
    end
    // Up/down counting steered by the trigger level
    wr(OFS_CONTROL_STATUS, 8'h00);
    wr(OFS_MODE_CONTROL, 8'h01);
    wr2(OFS_RELOAD_LOW, 16'h0010);
    wr2(OFS_COUNT_LOW, 16'h0011);
    pins.set_trig(0);
    wr(OFS_CONTROL_STATUS, 8'h06);
    repeat (2) pins.fall();
    rd(OFS_COUNT_HIGH, 8'hFF);
    rd(OFS_CONTROL_STATUS, 8'hC6);
    wr(OFS_CONTROL_STATUS, 8'h46);
    repeat (2) @(posedge clk);
    chk("irq", 33'h0, 33'(irq));
    pins.set_trig(1);
    pins.fall();
    rd(OFS_COUNT_LOW, 8'h10);
    rd(OFS_CONTROL_STATUS, 8'h86);
    // Baud ticks for every prescaler value and port choice
    wr(OFS_CONTROL_STATUS, 8'h00);
    wr2(OFS_RELOAD_LOW, 16'hFFFF);
    wr2(OFS_COUNT_LOW, 16'hFFFF);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_MODE_CONTROL, {4'h0, p[1:0], 2'b00});
      wr(OFS_CONTROL_STATUS, {2'b00, 2'(p % 3 + 1), 4'h4});
      repeat (12) @(posedge clk);
      t0 = ticks;
      repeat (120) @(posedge clk);
      t0 = ticks - t0 - 40 / (p + 1);
      chk("baud ticks", 33'h1, 33'(t0 == 0 || t0 == 1));
      chk("port select", 33'(p % 3 + 1), 33'(ssel));
      rd(OFS_CONTROL_STATUS, {2'b00, 2'(p % 3 + 1), 4'h4});
      wr(OFS_CONTROL_STATUS, {2'b00, 2'(p % 3 + 1), 4'h0});
    end
    // Clock-out alone, then together with baud ticks
    for (int s = 0; s < 2; s++) begin
      wr(OFS_MODE_CONTROL, 8'h02);
      wr(OFS_CONTROL_STATUS, {3'b000, s[0], 4'h0});
      wr2(OFS_RELOAD_LOW, 16'hFFFF);
      wr2(OFS_COUNT_LOW, 16'hFFFF);
      wr(OFS_CONTROL_STATUS, {3'b000, s[0], 4'h4});
      repeat (12) @(posedge clk);
      t0 = togs;
      t1 = ticks;
      repeat (60) @(posedge clk);
      chk("pin toggles", 33'd20, 33'(togs - t0));
      chk("ticks", 33'(s * 20), 33'(ticks - t1));
      chk("pin enable", 33'h1, 33'(pin_oe));
      chk("irq", 33'h0, 33'(irq));
      rd(OFS_CONTROL_STATUS, {3'b000, s[0], 4'h4});
      wr(OFS_CONTROL_STATUS, {3'b000, s[0], 4'h0});
    end
    // Baud mode trigger sets the flag only; stopped mode holds the count
    v = 16'($urandom);
    wr2(OFS_COUNT_LOW, v);
    wr(OFS_CONTROL_STATUS, 8'h18);
    pins.trig_fall();
    rd(OFS_COUNT_LOW, v[7:0]);
    rd(OFS_CONTROL_STATUS, 8'h58);
    chk("irq", 33'h1, 33'(irq));
    wr(OFS_CONTROL_STATUS, 8'h05);
    repeat (12) @(posedge clk);
    rd(OFS_COUNT_LOW, v[7:0]);
    rd(OFS_COUNT_HIGH, v[15:8]);
    chk("pin enable", 33'h0, 33'(pin_oe));
    conclude();
  end
endmodule
